/* File: pkg/hs_port_pkg.sv */
package hs_port_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam logic [15:0] PORT0_ADDR = 16'h1c00;
    localparam logic [15:0] PORT1_ADDR = 16'h1c01;
    localparam logic [15:0] PORT2_ADDR = 16'h1c02;
    // Handshake bit positions on port two.
    localparam int unsigned B_HANDSHAKE_IRQ_A = 3;
    localparam int unsigned B_STB_A  = 4;
    localparam int unsigned B_IBF_A  = 5;
    localparam int unsigned B_ACK_A  = 6;
    localparam int unsigned B_OBF_A  = 7;
    localparam int unsigned B_HANDSHAKE_IRQ_B = 0;
    localparam int unsigned B_BUF_B  = 1;
    localparam int unsigned B_STB_B  = 2;
    localparam int unsigned B_LOW3   = 3;
    // Group mode codes.
    localparam logic [3:0] MODE_OUT_OUT = 4'h0;
    localparam logic [3:0] MODE_OUT_IN  = 4'h1;
    localparam logic [3:0] MODE_IN_OUT  = 4'h2;
    localparam logic [3:0] MODE_IN_IN   = 4'h3;
    localparam logic [3:0] MODE_HSO_OUT = 4'h4;
    localparam logic [3:0] MODE_HSO_IN  = 4'h5;
    localparam logic [3:0] MODE_HSI_OUT = 4'h6;
    localparam logic [3:0] MODE_HSI_IN  = 4'h7;
    localparam logic [3:0] MODE_BIDIR   = 4'h8;
    localparam logic [7:0] MASK_UPPER = 8'hf0;
    localparam logic [7:0] MASK_LOWER = 8'h0f;
    localparam logic [7:0] MASK_GATES = 8'h54;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] ONES_BYTE  = 8'hff;

    typedef enum logic [2:0] {
        PORT_READ_CMD,
        PORT_WRITE_CMD,
        PORT_CONFIGURE_CMD,
        SINGLE_BIT_SET_CMD,
        SINGLE_BIT_CLEAR_CMD
    } cmd_op_type;

    typedef struct packed {
        cmd_op_type  op;
        logic [15:0] addr;
        logic [7:0]  data;
    } cmd_type;

    typedef struct packed {
        logic [7:0] p0;
        logic [7:0] p1;
        logic [7:0] p2;
    } pins_type;
endpackage

/* File: src/handshake_parallel_port_ctrl.sv */
`timescale 1ns/100ps
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,       // System clock.
    input  wire logic             rst_n,     // Synchronised reset.
    input  wire logic             in_valid,  // Push request.
    output logic                  in_ready,  // Room available.
    input  wire logic [WIDTH-1:0] in_data,   // Push data.
    output logic                  out_valid, // Data available.
    input  wire logic             out_ready, // Pop request.
    output logic [WIDTH-1:0]      out_data   // Head data.
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_type;
    fifo_state_type s;
    fifo_state_type next_s;
    logic           push;
    logic           pop;

    assign in_ready  = s.cnt != (AW+1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data  = s.mem[s.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr        = AW'(s.wr + 1'b1);
        end
        if (pop) begin
            next_s.rd = AW'(s.rd + 1'b1);
        end
        next_s.cnt = (AW+1)'(s.cnt + push - pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

module handshake_parallel_port_ctrl (
    input  wire logic                clk_sys_i,     // System clock, 100 MHz.
    input  wire logic                arst_n_i,      // Asynchronous reset, active low.
    input  wire logic                cmd_valid_i,   // Command strobe, one cycle.
    input  wire hs_port_pkg::cmd_type cmd_i,        // Command word.
    output logic [7:0]               rd_data_o,     // Read answer.
    output logic                     rd_valid_o,    // Read answer strobe.
    input  wire hs_port_pkg::pins_type pins_i,      // Pin levels in.
    output hs_port_pkg::pins_type    pins_o,        // Pin levels out.
    output hs_port_pkg::pins_type    pins_oe_n_o    // Pin drive enables, low drives.
);
    typedef struct packed {
        logic [3:0]            amode;
        logic [3:0]            bmode;
        logic [7:0]            lat0;
        logic [7:0]            lat1;
        logic [7:0]            lat2;
        logic [7:0]            in1;
        logic                  in1_full;
        logic                  obf0_n;
        logic                  obf1_n;
        logic                  irq0;
        logic                  irq1;
        hs_port_pkg::pins_type prev;
        hs_port_pkg::pins_type po;
        hs_port_pkg::pins_type poe_n;
        logic [7:0]            rdata;
        logic                  rvalid;
    } state_type;

    state_type  s;
    state_type  next_s;
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       a_hso;
    logic       a_hsi;
    logic       b_hso;
    logic       b_hsi;
    logic       stb0_fall;
    logic       ack0_fall;
    logic       stb1_fall;
    logic       ack1_fall;
    logic       fifo_ready;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [7:0] fifo_data;
    logic       wr0;
    logic       rd0;
    logic [7:0] drv2;

    // Bits of port two driven by the device in the given mode pair.
    function automatic logic [7:0] p2_drive(input logic [3:0] am, input logic [3:0] bm);
        logic [7:0] m;
        m = hs_port_pkg::ZERO_BYTE;
        unique case (am)
            hs_port_pkg::MODE_OUT_OUT, hs_port_pkg::MODE_IN_OUT: m = hs_port_pkg::MASK_UPPER;
            hs_port_pkg::MODE_HSO_OUT: m = 8'h00b8;
            hs_port_pkg::MODE_HSO_IN:  m = 8'h0088;
            hs_port_pkg::MODE_HSI_OUT: m = 8'h00e8;
            hs_port_pkg::MODE_HSI_IN, hs_port_pkg::MODE_BIDIR: m = 8'h0028;
            default: m = hs_port_pkg::ZERO_BYTE;
        endcase
        unique case (bm)
            hs_port_pkg::MODE_OUT_OUT, hs_port_pkg::MODE_IN_OUT: begin
                m[2:0] = 3'h7;
                if (am < hs_port_pkg::MODE_HSO_OUT) begin
                    m[hs_port_pkg::B_LOW3] = 1'b1;
                end
            end
            hs_port_pkg::MODE_HSO_OUT, hs_port_pkg::MODE_HSI_OUT: m[1:0] = 2'h3;
            default: m = m;
        endcase
        return m;
    endfunction

    // Whether a port data byte is driven in the given group mode.
    function automatic logic port_out(input logic [3:0] md, input logic grp_a);
        return md == hs_port_pkg::MODE_OUT_OUT || md == hs_port_pkg::MODE_OUT_IN ||
               md == hs_port_pkg::MODE_HSO_OUT || (grp_a && md == hs_port_pkg::MODE_HSO_IN);
    endfunction

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign a_hso = s.amode == hs_port_pkg::MODE_HSO_OUT || s.amode == hs_port_pkg::MODE_HSO_IN;
    assign a_hsi = s.amode == hs_port_pkg::MODE_HSI_OUT || s.amode == hs_port_pkg::MODE_HSI_IN ||
                   s.amode == hs_port_pkg::MODE_BIDIR;
    assign b_hso = s.bmode == hs_port_pkg::MODE_HSO_OUT;
    assign b_hsi = s.bmode == hs_port_pkg::MODE_HSI_OUT;
    assign stb0_fall = a_hsi && s.prev.p2[hs_port_pkg::B_STB_A] && !pins_i.p2[hs_port_pkg::B_STB_A];
    assign ack0_fall = a_hso && s.prev.p2[hs_port_pkg::B_ACK_A] && !pins_i.p2[hs_port_pkg::B_ACK_A];
    assign stb1_fall = b_hsi && s.prev.p2[hs_port_pkg::B_STB_B] && !pins_i.p2[hs_port_pkg::B_STB_B];
    assign ack1_fall = b_hso && s.prev.p2[hs_port_pkg::B_STB_B] && !pins_i.p2[hs_port_pkg::B_STB_B];
    assign wr0 = cmd_valid_i && cmd_i.op == hs_port_pkg::PORT_WRITE_CMD && cmd_i.addr == hs_port_pkg::PORT0_ADDR;
    assign rd0 = cmd_valid_i && cmd_i.op == hs_port_pkg::PORT_READ_CMD && cmd_i.addr == hs_port_pkg::PORT0_ADDR;
    assign fifo_pop = rd0 && a_hsi;
    assign drv2 = p2_drive(s.amode, s.bmode);

    // Port zero input data queue; the peripheral sees it full as input buffer full.
    byte_fifo #(
        .WIDTH (hs_port_pkg::DATA_W),
        .DEPTH (hs_port_pkg::FIFO_DEPTH)
    ) u_in0_fifo (
        .clk       (clk_sys_i),
        .rst_n     (rst_n),
        .in_valid  (stb0_fall),
        .in_ready  (fifo_ready),
        .in_data   (pins_i.p0),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    always_comb begin
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.prev   = pins_i;
        if (cmd_valid_i) begin
            unique case (cmd_i.op)
                hs_port_pkg::PORT_CONFIGURE_CMD: begin
                    next_s.amode = cmd_i.data[3:0];
                    next_s.bmode = cmd_i.data[7:4];
                    next_s.lat2  = s.lat2 & ~hs_port_pkg::MASK_GATES;
                end
                hs_port_pkg::SINGLE_BIT_SET_CMD: next_s.lat2[cmd_i.data[2:0]] = 1'b1;
                hs_port_pkg::SINGLE_BIT_CLEAR_CMD: next_s.lat2[cmd_i.data[2:0]] = 1'b0;
                hs_port_pkg::PORT_WRITE_CMD: begin
                    if (cmd_i.addr == hs_port_pkg::PORT0_ADDR && port_out(s.amode, 1'b1)) begin
                        next_s.lat0 = cmd_i.data;
                        if (a_hso) begin
                            next_s.obf0_n = 1'b0;
                            next_s.irq0   = 1'b0;
                        end
                    end
                    if (cmd_i.addr == hs_port_pkg::PORT1_ADDR && port_out(s.bmode, 1'b0)) begin
                        next_s.lat1 = cmd_i.data;
                        if (b_hso) begin
                            next_s.obf1_n = 1'b0;
                            next_s.irq1   = 1'b0;
                        end
                    end
                    if (cmd_i.addr == hs_port_pkg::PORT2_ADDR) begin
                        next_s.lat2[3:0] = cmd_i.data[3:0];
                    end
                end
                hs_port_pkg::PORT_READ_CMD: begin
                    next_s.rvalid = 1'b1;
                    unique case (cmd_i.addr)
                        hs_port_pkg::PORT0_ADDR: begin
                            if (a_hsi) begin
                                next_s.rdata = fifo_data;
                                next_s.irq0  = !fifo_valid ? s.irq0 : 1'b0;
                            end else if (port_out(s.amode, 1'b1)) begin
                                next_s.rdata = s.lat0;
                            end else begin
                                next_s.rdata = pins_i.p0;
                            end
                        end
                        hs_port_pkg::PORT1_ADDR: begin
                            if (b_hsi) begin
                                next_s.rdata    = s.in1;
                                next_s.in1_full = 1'b0;
                                next_s.irq1     = 1'b0;
                            end else if (port_out(s.bmode, 1'b0)) begin
                                next_s.rdata = s.lat1;
                            end else begin
                                next_s.rdata = pins_i.p1;
                            end
                        end
                        hs_port_pkg::PORT2_ADDR: next_s.rdata = (s.lat2 & drv2) | (pins_i.p2 & ~drv2);
                        default: next_s.rdata = hs_port_pkg::ZERO_BYTE;
                    endcase
                end
                default: next_s = next_s;
            endcase
        end
        // Hardware events are applied last so they win over a same-cycle clear.
        if (stb0_fall && fifo_ready) begin
            next_s.irq0 = 1'b1;
        end
        if (ack0_fall) begin
            next_s.obf0_n = 1'b1;
            next_s.irq0   = 1'b1;
        end
        if (stb1_fall && !s.in1_full) begin
            next_s.in1      = pins_i.p1;
            next_s.in1_full = 1'b1;
            next_s.irq1     = 1'b1;
        end
        if (ack1_fall) begin
            next_s.obf1_n = 1'b1;
            next_s.irq1   = 1'b1;
        end
        // Pin drivers are built from the present state, one cycle behind it.
        next_s.po.p0    = s.lat0;
        next_s.po.p1    = s.lat1;
        next_s.poe_n.p0 = port_out(s.amode, 1'b1) ? hs_port_pkg::ZERO_BYTE : hs_port_pkg::ONES_BYTE;
        next_s.poe_n.p1 = port_out(s.bmode, 1'b0) ? hs_port_pkg::ZERO_BYTE : hs_port_pkg::ONES_BYTE;
        next_s.poe_n.p2 = ~drv2;
        next_s.po.p2    = s.lat2;
        if (a_hso) begin
            next_s.po.p2[hs_port_pkg::B_OBF_A]  = s.obf0_n;
            next_s.po.p2[hs_port_pkg::B_HANDSHAKE_IRQ_A] = s.irq0 && s.lat2[hs_port_pkg::B_ACK_A];
        end
        if (a_hsi) begin
            next_s.po.p2[hs_port_pkg::B_IBF_A]  = !fifo_ready;
            next_s.po.p2[hs_port_pkg::B_HANDSHAKE_IRQ_A] = s.irq0 && s.lat2[hs_port_pkg::B_STB_A];
        end
        if (b_hso || b_hsi) begin
            next_s.po.p2[hs_port_pkg::B_BUF_B]  = b_hso ? s.obf1_n : s.in1_full;
            next_s.po.p2[hs_port_pkg::B_HANDSHAKE_IRQ_B] = s.irq1 && s.lat2[hs_port_pkg::B_STB_B];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.amode    <= hs_port_pkg::MODE_IN_IN;
            s.bmode    <= hs_port_pkg::MODE_IN_IN;
            s.obf0_n   <= 1'b1;
            s.obf1_n   <= 1'b1;
            s.poe_n    <= '1;
            s.prev     <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_o   = s.rdata;
    assign rd_valid_o  = s.rvalid;
    assign pins_o      = s.po;
    assign pins_oe_n_o = s.poe_n;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    chk_obf_write_low: assert property ((wr0 && a_hso && !ack0_fall) |=> !s.obf0_n)
        else $error("output buffer full not driven low after write");
    chk_obf_ack_high: assert property (ack0_fall |=> s.obf0_n ##1 pins_o.p2[7])
        else $error("output buffer full not released by acknowledge");
    chk_irq_in_gate: assert property ((a_hsi && !s.lat2[4]) |=> !pins_o.p2[3])
        else $error("input interrupt request passed while gated");
    chk_irq_out_set: assert property ((ack0_fall && next_s.lat2[6]) |=> ##1 pins_o.p2[3])
        else $error("output interrupt request missing after acknowledge");
    chk_cfg_clear_gate: assert property ((cmd_valid_i && cmd_i.op == hs_port_pkg::PORT_CONFIGURE_CMD)
        |=> (s.lat2 & 8'h0054) == 8'h0000)
        else $error("configure left a gating bit set");
    chk_latch_readback: assert property ((rd0 && port_out(s.amode, 1'b1) && !a_hsi)
        |=> rd_valid_o && rd_data_o == $past(s.lat0))
        else $error("output port read did not return its latch");
    chk_in1_capture: assert property ((stb1_fall && !s.in1_full)
        |=> s.in1_full && s.in1 == $past(pins_i.p1) ##1 pins_o.p2[1])
        else $error("port one strobe not captured");
    chk_upper_keep: assert property ((cmd_valid_i && cmd_i.op == hs_port_pkg::PORT_WRITE_CMD
        && cmd_i.addr == hs_port_pkg::PORT2_ADDR) |=> s.lat2[7:4] == $past(s.lat2[7:4]))
        else $error("whole write changed upper port two bits");
    chk_stb_irq: assert property ((stb0_fall && fifo_ready) |=> s.irq0)
        else $error("strobe did not raise the request");

    cov_strobe_in: cover property (stb0_fall ##[1:20] rd0);
    cov_ack_out: cover property (wr0 && a_hso ##[1:20] ack0_fall);
    cov_fifo_full: cover property (!fifo_ready);
    cov_config: cover property (cmd_valid_i && cmd_i.op == hs_port_pkg::PORT_CONFIGURE_CMD);
endmodule

/* File: tb/hs_peer_model.sv */
`timescale 1ns/100ps
module hs_peer_model (
    input  wire logic        clk_i,  // System clock.
    input  wire logic [23:0] line_i, // Resolved pin levels.
    output logic      [23:0] drv_o   // Peripheral drive values.
);
    // Strobe and acknowledge lines idle high.
    initial drv_o = 24'h00_00ff;

    task automatic put(input logic [23:0] v);
        @(posedge clk_i);
        #1 drv_o = v;
    endtask

    // Presents one byte under an input strobe, holding off while the buffer reports full.
    task automatic strobe(input logic port1, input logic [7:0] d);
        int i;
        for (i = 0; i < 20 && line_i[port1 ? 1 : 5] === 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
        if (port1) drv_o[15:8] = d;
        else drv_o[23:16] = d;
        drv_o[port1 ? 2 : 4] = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 drv_o[port1 ? 2 : 4] = 1'b1;
        @(posedge clk_i);
        // Released data lines flip so that a late capture cannot match by chance.
        #1 drv_o[23:8] = ~drv_o[23:8];
    endtask

    task automatic ack(input logic port1);
        @(posedge clk_i);
        #1 drv_o[port1 ? 2 : 6] = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 drv_o[port1 ? 2 : 6] = 1'b1;
    endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
    logic                  clk_sys_i   = 1'b0;
    logic                  arst_n_i    = 1'b0;
    logic                  cmd_valid_i = 1'b0;
    hs_port_pkg::cmd_type  cmd_i       = '0;
    logic [7:0]            rd_data_o;
    logic                  rd_valid_o;
    hs_port_pkg::pins_type pins_i;
    hs_port_pkg::pins_type pins_o;
    hs_port_pkg::pins_type pins_oe_n_o;
    logic [23:0]           peer_drv;
    int                    bad_count   = 0;
    int                    n_compared  = 0;

    // Each wire carries the device value where it drives, else the peripheral value.
    assign pins_i = (pins_oe_n_o & peer_drv) | (~pins_oe_n_o & pins_o);
    always #5 clk_sys_i = ~clk_sys_i;

    handshake_parallel_port_ctrl u_dut (
        .clk_sys_i   (clk_sys_i),
        .arst_n_i    (arst_n_i),
        .cmd_valid_i (cmd_valid_i),
        .cmd_i       (cmd_i),
        .rd_data_o   (rd_data_o),
        .rd_valid_o  (rd_valid_o),
        .pins_i      (pins_i),
        .pins_o      (pins_o),
        .pins_oe_n_o (pins_oe_n_o)
    );
    hs_peer_model u_peer (.clk_i(clk_sys_i), .line_i(pins_i), .drv_o(peer_drv));

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(input hs_port_pkg::cmd_op_type op, input int p, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 cmd_valid_i = 1'b1;
        cmd_i = '{op, hs_port_pkg::PORT0_ADDR + 16'(p), d};
        @(posedge clk_sys_i);
        #1 cmd_valid_i = 1'b0;
    endtask

    task automatic cfg(input logic [3:0] a, input logic [3:0] b);
        cmd(hs_port_pkg::PORT_CONFIGURE_CMD, 0, {b, a});
    endtask

    task automatic wr(input int p, input logic [7:0] d);
        cmd(hs_port_pkg::PORT_WRITE_CMD, p, d);
    endtask

    task automatic bit_op(input logic set, input int b);
        cmd(set ? hs_port_pkg::SINGLE_BIT_SET_CMD : hs_port_pkg::SINGLE_BIT_CLEAR_CMD, 0, 8'(b));
    endtask

    task automatic rd(input int p, input logic [7:0] exp, input string what);
        int i;
        cmd(hs_port_pkg::PORT_READ_CMD, p, 8'h00);
        for (i = 0; i < 3 && rd_valid_o !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk(what, exp, (rd_valid_o === 1'b1) ? rd_data_o : 8'hxx);
    endtask

    // Waits a bounded time for a port two output level, or checks it once after ten cycles when stay is set.
    task automatic see_bit(input int b, input logic v, input string what, input logic stay = 1'b0);
        int i;
        for (i = 0; i < 10 && (stay || pins_o.p2[b] !== v); i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk(what, {7'h00, v}, {7'h00, pins_o.p2[b]});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic t_reset();
        chk("oe p0", 8'hff, pins_oe_n_o.p0);
        chk("oe p2", 8'hff, pins_oe_n_o.p2);
        u_peer.put(24'h3c_96f5);
        rd(0, 8'h3c, "rd p0");
        rd(1, 8'h96, "rd p1");
        rd(2, 8'hf5, "rd p2");
        // Every port two input bit takes both levels here, so no port two pin stays at a fixed value.
        u_peer.put(24'h5a_960a);
        rd(0, 8'h5a, "rd p0 live");
        rd(2, 8'h0a, "rd p2 live");
        rd(3, 8'h00, "rd bad addr");
    endtask

    task automatic t_simple();
        cfg(4'h1, 4'h2);
        u_peer.put(24'h00_5af5);
        wr(0, 8'hc3);
        settle();
        chk("p0 out", 8'hc3, pins_o.p0);
        chk("oe p0", 8'h00, pins_oe_n_o.p0);
        chk("oe p1", 8'hff, pins_oe_n_o.p1);
        chk("oe p2", 8'hf0, pins_oe_n_o.p2);
        rd(0, 8'hc3, "p0 latch");
        wr(0, 8'hc4);
        rd(0, 8'hc4, "p0 rmw");
        rd(1, 8'h5a, "p1 pins");
        wr(1, 8'h11);
        rd(1, 8'h5a, "p1 no write");
        wr(2, 8'h0a);
        rd(2, 8'hfa, "p2 mixed");
        cfg(4'h0, 4'h0);
        wr(2, 8'hff);
        bit_op(1'b1, 7);
        bit_op(1'b0, 0);
        settle();
        chk("p2 upper", 8'h8e, pins_o.p2);
    endtask

    task automatic t_hs_out();
        cfg(4'h4, 4'h0);
        settle();
        chk("oe p2 hs out", 8'h40, pins_oe_n_o.p2);
        bit_op(1'b1, 6);
        wr(0, 8'ha5);
        see_bit(7, 1'b0, "obf low");
        chk("p0 hs out", 8'ha5, pins_o.p0);
        u_peer.ack(1'b0);
        see_bit(7, 1'b1, "obf high");
        see_bit(3, 1'b1, "irq out");
        wr(2, 8'h00);
        see_bit(3, 1'b1, "bit3 kept", 1'b1);
        wr(0, 8'ha6);
        see_bit(3, 1'b0, "irq clr wr");
        u_peer.ack(1'b0);
        see_bit(3, 1'b1, "irq again");
        cfg(4'h4, 4'h0);
        wr(0, 8'ha7);
        u_peer.ack(1'b0);
        see_bit(3, 1'b0, "gate cleared", 1'b1);
    endtask

    task automatic t_hs_in();
        cfg(4'h6, 4'h0);
        bit_op(1'b1, 4);
        u_peer.strobe(1'b0, 8'h11);
        see_bit(3, 1'b1, "irq in");
        rd(0, 8'h11, "p0 latched");
        see_bit(3, 1'b0, "irq clr rd");
        bit_op(1'b0, 4);
        u_peer.strobe(1'b0, 8'h22);
        see_bit(3, 1'b0, "irq gated", 1'b1);
        rd(0, 8'h22, "p0 gated");
        for (int i = 0; i < 32; i++) u_peer.strobe(1'b0, 8'(i * 7));
        see_bit(5, 1'b1, "buf full");
        for (int i = 0; i < 32; i++) rd(0, 8'(i * 7), "fifo order");
        see_bit(5, 1'b0, "buf free");
    endtask

    task automatic t_port1();
        cfg(4'h0, 4'h6);
        bit_op(1'b1, 2);
        u_peer.strobe(1'b1, 8'h77);
        see_bit(1, 1'b1, "p1 ibf");
        see_bit(0, 1'b1, "p1 irq");
        rd(1, 8'h77, "p1 latched");
        see_bit(0, 1'b0, "p1 irq clr");
        cfg(4'h0, 4'h4);
        bit_op(1'b1, 2);
        wr(1, 8'h3e);
        see_bit(1, 1'b0, "p1 obf low");
        u_peer.ack(1'b1);
        see_bit(1, 1'b1, "p1 obf high");
        see_bit(0, 1'b1, "p1 irq out");
    endtask

    initial begin
        #100_000;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        t_reset();
        t_simple();
        t_hs_out();
        t_hs_in();
        t_port1();
        test_done();
    end
endmodule
